/* hdl/ssp_consts.svh */
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// ==========================================
// register byte offsets
`define SSP_ADDR_CTRL   4'h0
`define SSP_ADDR_STAT   4'h4
`define SSP_ADDR_DATA   4'h8
`define SSP_ADDR_MASK   4'hc
// ==========================================
// control fields
`define SSP_CTRL_RESET  8'h20
`define SSP_CTRL_WMASK  8'hfe
`define SSP_BIT_RIE     7
`define SSP_BIT_MODE_FAULT_ENABLE  6
`define SSP_BIT_MSTR    5
`define SSP_BIT_CLOCK_POLARITY_SELECT    4
`define SSP_BIT_CLOCK_PHASE_SELECT    3
`define SSP_BIT_ODRAIN  2
`define SSP_BIT_PE      1
// ==========================================
// status fields
`define SSP_ST_RXFULL   0
`define SSP_ST_MODE_FAULT_FLAG     1
`define SSP_ST_TXEMPTY  2
`define SSP_ST_BUSY     3
// ==========================================
// bus answers and timing
`define SSP_RESP_OKAY   2'h0
`define SSP_RESP_SLVERR 2'h2
`define SSP_CLK_PERIOD_NS  50
`define SSP_SCLK_PERIOD_NS 400
`define SSP_HALF_CYC    (`SSP_SCLK_PERIOD_NS / 2 / `SSP_CLK_PERIOD_NS)
`endif

/* hdl/ssp_pkg.sv */
package ssp_pkg;
   typedef enum logic {XS_IDLE, XS_SHIFT} ssp_xfer_state_t;
   typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_SHIFT, HS_GAP} ssp_host_state_t;
endpackage

/* hdl/ssp_link_if.sv */
`timescale 1ns/100ps
interface ssp_link_if;
   logic sclkD;
   logic sclkDOe;
   logic mosiD;
   logic mosiDOe;
   logic misoD;
   logic misoDOe;
   logic sclkH;
   logic sclkHOe;
   logic mosiH;
   logic mosiHOe;
   logic ssN;
   logic sclk;
   logic mosi;
   logic miso;

   // ==========================================
   // wire levels; undriven lines are pulled high
   assign sclk = sclkDOe ? sclkD : (sclkHOe ? sclkH : 1'h1);
   assign mosi = mosiDOe ? mosiD : (mosiHOe ? mosiH : 1'h1);
   assign miso = misoDOe ? misoD : 1'h1;

   modport dev (output sclkD, sclkDOe, mosiD, mosiDOe, misoD, misoDOe,
                input  sclk, mosi, miso, ssN);
   modport host (output sclkH, sclkHOe, mosiH, mosiHOe, ssN,
                 input  miso);
endinterface

/* hdl/ssp_sync.sv */
`timescale 1ns/100ps
module ssp_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // pins in, filtered levels out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[i]  <= INIT[i];
               s2_r[i]  <= INIT[i];
               s3_r[i]  <= INIT[i];
               dout[i]  <= INIT[i];
            end else begin
               s1_r[i] <= din[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               // a change counts only once two stages agree
               if (s2_r[i] == s3_r[i]) begin
                  dout[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate
endmodule

/* hdl/ssp_port.sv */
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "ssp_consts.svh"
module ssp_port #(
   parameter int unsigned DIV = `SSP_HALF_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // axi4-lite write
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // interrupt
   output logic             irq,
   // serial link
   ssp_link_if.dev          link
);
   // ==========================================
   // helpers
   function automatic logic isMapped(input logic [3:0] a);
      return a[1:0] == 2'h0;
   endfunction

   // open-drain pins only ever pull low
   function automatic logic padOe(input logic drv, input logic od, input logic v);
      return drv & (~od | ~v);
   endfunction

   // ==========================================
   // state
   ssp_pkg::ssp_xfer_state_t state_r;
   logic [7:0] ctrl_r;
   logic [7:0] mask_r;
   logic [2:0] stat_r;
   logic [7:0] txData_r;
   logic       txFull_r;
   logic [7:0] rxData_r;
   logic [7:0] shift_r;
   logic       outBit_r;
   logic       inBit_r;
   logic [2:0] bitCnt_r;
   logic [3:0] halfCnt_r;
   logic [7:0] divCnt_r;
   logic       sclkPrev_r;
   logic       ssPrev_r;
   logic       awHeld_r;
   logic       wHeld_r;
   logic [3:0] awAddr_r;
   logic [7:0] wData_r;
   logic       wLane0_r;
   logic       sclkS;
   logic       mosiS;
   logic       misoS;
   logic       ssNS;

   ssp_sync #(.W(4), .INIT(4'hf)) i_ssp_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .din  ({link.sclk, link.mosi, link.miso, link.ssN}),
      .dout ({sclkS, mosiS, misoS, ssNS})
   );

   // ==========================================
   // mode decode
   logic pe, isMaster, isSlave, clock_polarity_select, clock_phase_select, od, ssSel, modfHit;
   assign pe       = ctrl_r[`SSP_BIT_PE];
   assign isMaster = pe & ctrl_r[`SSP_BIT_MSTR];
   assign isSlave  = pe & ~ctrl_r[`SSP_BIT_MSTR];
   assign clock_polarity_select     = ctrl_r[`SSP_BIT_CLOCK_POLARITY_SELECT];
   assign clock_phase_select     = ctrl_r[`SSP_BIT_CLOCK_PHASE_SELECT];
   assign od       = ctrl_r[`SSP_BIT_ODRAIN];
   assign ssSel    = isSlave & ~ssNS;
   assign modfHit  = isMaster & ctrl_r[`SSP_BIT_MODE_FAULT_ENABLE] & ~ssNS;

   // ==========================================
   // edges
   logic busy, tick, slvEdge, lead, trail, lastTrail, din, ssFall;
   logic start, slaveLoad, masterLoad, abortX, done;
   logic [7:0] rxByte;
   assign busy    = state_r == ssp_pkg::XS_SHIFT;
   assign tick    = isMaster & busy & (divCnt_r == 8'(DIV - 1));
   assign slvEdge = busy & ssSel & (sclkS != sclkPrev_r);
   assign lead    = isMaster ? tick & ~halfCnt_r[0] : slvEdge & (sclkS != clock_polarity_select);
   assign trail   = isMaster ? tick & halfCnt_r[0] : slvEdge & (sclkS == clock_polarity_select);
   assign lastTrail = trail & (bitCnt_r == 3'h7);
   assign din     = isMaster ? misoS : mosiS;
   assign ssFall  = ssPrev_r & ~ssNS;
   assign rxByte  = clock_phase_select ? {shift_r[7:1], din} : {shift_r[6:0], inBit_r};

   assign masterLoad = ~busy & isMaster & txFull_r & ~modfHit;
   // slave refills its shifter only while idle and deselected
   assign slaveLoad  = ~busy & isSlave & txFull_r & ssNS;
   assign start      = (~busy & isSlave & ssFall) | masterLoad;
   assign abortX     = ~pe | (isSlave & ssNS) | modfHit;
   assign done       = busy & lastTrail & ~abortX;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ssp_pkg::XS_IDLE;
      end else begin
         case (state_r)
            ssp_pkg::XS_IDLE: begin
               if (start) begin
                  state_r <= ssp_pkg::XS_SHIFT;
               end
            end
            ssp_pkg::XS_SHIFT: begin
               if (lastTrail || abortX) begin
                  state_r <= ssp_pkg::XS_IDLE;
               end
            end
            default: state_r <= ssp_pkg::XS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclkPrev_r <= 1'h1;
         ssPrev_r   <= 1'h1;
         divCnt_r   <= 8'h00;
      end else begin
         sclkPrev_r <= sclkS;
         ssPrev_r   <= ssNS;
         if (!busy || tick) begin
            divCnt_r <= 8'h00;
         end else begin
            divCnt_r <= divCnt_r + 8'h01;
         end
      end
   end

   // ==========================================
   // shifter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r   <= 8'h00;
         outBit_r  <= 1'h0;
         inBit_r   <= 1'h0;
         bitCnt_r  <= 3'h0;
         halfCnt_r <= 4'h0;
      end else if (start) begin
         bitCnt_r  <= 3'h0;
         halfCnt_r <= 4'h0;
         if (isMaster) begin
            shift_r  <= txData_r;
            outBit_r <= txData_r[7];
         end else begin
            outBit_r <= shift_r[7];
         end
      end else if (slaveLoad) begin
         shift_r <= txData_r;
      end else if (!busy) begin
         halfCnt_r <= 4'h0;
      end else begin
         if (tick) begin
            halfCnt_r <= halfCnt_r + 4'h1;
         end
         if (lead) begin
            if (clock_phase_select) begin
               outBit_r <= shift_r[7];
               shift_r  <= {shift_r[6:0], 1'h0};
            end else begin
               inBit_r <= din;
            end
         end
         if (trail) begin
            bitCnt_r <= bitCnt_r + 3'h1;
            if (clock_phase_select) begin
               shift_r[0] <= din;
            end else begin
               shift_r  <= {shift_r[6:0], inBit_r};
               outBit_r <= shift_r[6];
            end
         end
      end
   end

   // ==========================================
   // axi4-lite slave
   logic doWr, arHs, wrCtrl, wrData, wrMask, rdStat;
   assign awready = ~awHeld_r & ~bvalid;
   assign wready  = ~wHeld_r & ~bvalid;
   assign arready = ~rvalid;
   assign doWr    = awHeld_r & wHeld_r & ~bvalid;
   assign arHs    = arvalid & arready;
   assign wrCtrl  = doWr & wLane0_r & (awAddr_r == `SSP_ADDR_CTRL);
   assign wrData  = doWr & wLane0_r & (awAddr_r == `SSP_ADDR_DATA);
   assign wrMask  = doWr & wLane0_r & (awAddr_r == `SSP_ADDR_MASK);
   assign rdStat  = arHs & (araddr == `SSP_ADDR_STAT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_r <= 1'h0;
         wHeld_r  <= 1'h0;
         awAddr_r <= 4'h0;
         wData_r  <= 8'h00;
         wLane0_r <= 1'h0;
         bvalid   <= 1'h0;
         bresp    <= `SSP_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHeld_r <= 1'h1;
            awAddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_r  <= 1'h1;
            wData_r  <= wdata[7:0];
            wLane0_r <= wstrb[0];
         end
         if (doWr) begin
            awHeld_r <= 1'h0;
            wHeld_r  <= 1'h0;
            bvalid   <= 1'h1;
            bresp    <= isMapped(awAddr_r) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'h0;
         rdata  <= 32'h0000_0000;
         rresp  <= `SSP_RESP_OKAY;
      end else if (arHs) begin
         rvalid <= 1'h1;
         rresp  <= isMapped(araddr) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
         case (araddr)
            `SSP_ADDR_CTRL: rdata <= {24'h000000, ctrl_r};
            `SSP_ADDR_STAT: rdata <= {28'h0000000, busy, stat_r};
            `SSP_ADDR_DATA: rdata <= {24'h000000, rxData_r};
            `SSP_ADDR_MASK: rdata <= {29'h0000000, mask_r[2:0]};
            default:        rdata <= 32'h0000_0000;
         endcase
      end else if (rready) begin
         rvalid <= 1'h0;
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `SSP_CTRL_RESET;
         mask_r <= 8'h00;
      end else begin
         if (wrCtrl) begin
            ctrl_r <= wData_r & `SSP_CTRL_WMASK;
         end
         if (wrMask) begin
            mask_r <= {5'h00, wData_r[2:0]};
         end
      end
   end

   // a write while shifting only parks in the holding register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txData_r <= 8'h00;
         txFull_r <= 1'h0;
      end else if (wrData) begin
         txData_r <= wData_r;
         txFull_r <= 1'h1;
      end else if (masterLoad || slaveLoad) begin
         txFull_r <= 1'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxData_r <= 8'h00;
      end else if (done) begin
         rxData_r <= rxByte;
      end
   end

   // set beats the read-clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= 3'h0;
      end else begin
         stat_r <= (stat_r & ~{3{rdStat}})
                 | {masterLoad | slaveLoad, modfHit, done};
      end
   end

   assign irq = |(stat_r & mask_r[2:0] & {2'h3, ctrl_r[`SSP_BIT_RIE]});

   // ==========================================
   // pins
   logic mDrive, sclkOut;
   assign mDrive  = isMaster & ~modfHit;
   assign sclkOut = clock_polarity_select ^ halfCnt_r[0];
   assign link.sclkD   = sclkOut;
   assign link.sclkDOe = padOe(mDrive, od, sclkOut);
   assign link.mosiD   = outBit_r;
   assign link.mosiDOe = padOe(mDrive, od, outBit_r);
   assign link.misoD   = outBit_r;
   assign link.misoDOe = padOe(ssSel, od, outBit_r);
endmodule

/* hdl/ssp_master_end.sv */
`timescale 1ns/100ps
`include "ssp_consts.svh"
module ssp_master_end #(
   parameter int unsigned HALF  = `SSP_HALF_CYC,
   parameter int unsigned SETUP = 2 * `SSP_HALF_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // user side
   input  wire logic       start,
   input  wire logic [7:0] txByte,
   input  wire logic       clock_polarity_select,
   input  wire logic       drive,
   output logic            busy,
   output logic            done,
   output logic [7:0]      rxByte,
   // serial link
   ssp_link_if.host        link
);
   ssp_pkg::ssp_host_state_t state_r;
   logic [7:0] cnt_r;
   logic [3:0] halfCnt_r;
   logic [7:0] shift_r;
   logic [7:0] rx_r;
   logic       sclk_r;
   logic       ssN_r;
   logic       misoS;

   ssp_sync #(.W(1), .INIT(1'h1)) i_ssp_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (link.miso),
      .dout (misoS)
   );

   assign busy = state_r != ssp_pkg::HS_IDLE;

   // ==========================================
   // byte sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= ssp_pkg::HS_IDLE;
         cnt_r     <= 8'h00;
         halfCnt_r <= 4'h0;
         shift_r   <= 8'h00;
         rx_r      <= 8'h00;
         rxByte    <= 8'h00;
         sclk_r    <= 1'h0;
         ssN_r     <= 1'h1;
         done      <= 1'h0;
      end else begin
         done <= 1'h0;
         case (state_r)
            ssp_pkg::HS_IDLE: begin
               sclk_r <= clock_polarity_select;
               ssN_r  <= 1'h1;
               if (start) begin
                  shift_r <= txByte;
                  ssN_r   <= 1'h0;
                  cnt_r   <= 8'(SETUP - 1);
                  state_r <= ssp_pkg::HS_SETUP;
               end
            end
            ssp_pkg::HS_SETUP: begin
               if (cnt_r == 8'h00) begin
                  cnt_r     <= 8'(HALF - 1);
                  halfCnt_r <= 4'h0;
                  state_r   <= ssp_pkg::HS_SHIFT;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            ssp_pkg::HS_SHIFT: begin
               if (cnt_r == 8'h00) begin
                  cnt_r     <= 8'(HALF - 1);
                  sclk_r    <= ~sclk_r;
                  halfCnt_r <= halfCnt_r + 4'h1;
                  // both synchronisers sit in the miso loop, so a bit shows up
                  // about nine clocks after its shift edge: take it at the leading edge after
                  // next, a period and a half later; holds for HALF from 4 to 9
                  if (halfCnt_r[0]) begin
                     shift_r <= {shift_r[6:0], 1'h0};
                  end else if (halfCnt_r != 4'h0) begin
                     rx_r <= {rx_r[6:0], misoS};
                  end
                  if (halfCnt_r == 4'hf) begin
                     state_r <= ssp_pkg::HS_GAP;
                  end
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            ssp_pkg::HS_GAP: begin
               if (cnt_r != 8'h00) begin
                  cnt_r <= cnt_r - 8'h01;
               end else if (!ssN_r) begin
                  // last bit, one and a half periods after its edge
                  rx_r  <= {rx_r[6:0], misoS};
                  ssN_r <= 1'h1;
                  cnt_r <= 8'(SETUP - 1);
               end else begin
                  rxByte  <= rx_r;
                  done    <= 1'h1;
                  state_r <= ssp_pkg::HS_IDLE;
               end
            end
            default: state_r <= ssp_pkg::HS_IDLE;
         endcase
      end
   end

   assign link.sclkH   = sclk_r;
   assign link.sclkHOe = drive;
   assign link.mosiH   = shift_r[7];
   assign link.mosiHOe = drive;
   assign link.ssN     = ssN_r;
endmodule

/* verification/ssp_link_monitor.sv */
`timescale 1ns/100ps
module ssp_link_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wire levels
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ssN,
   // pads
   input wire logic mosiH,
   input wire logic mosiHOe,
   input wire logic mosiDOe,
   input wire logic sclkDOe,
   input wire logic misoDOe
);
   logic [3:0] hiCnt_r;
   logic [4:0] togCnt_r;
   logic       idleClk_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==========================================
   // helpers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) hiCnt_r <= 4'h0;
      else if (!ssN) hiCnt_r <= 4'h0;
      else if (hiCnt_r != 4'hf) hiCnt_r <= hiCnt_r + 4'h1;
   end
   // toggles of the shared clock within one frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) togCnt_r <= 5'h0;
      else if (ssN) togCnt_r <= 5'h0;
      else if ($changed(sclk) && togCnt_r != 5'h1f) togCnt_r <= togCnt_r + 5'h1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) idleClk_r <= 1'h0;
      else if (ssN) idleClk_r <= sclk;
   end

   // ==========================================
   // checks
   sel_drive_a: assert property (hiCnt_r >= 4'h8 |-> !misoDOe)
      else $error("miso driven while deselected");
   first_edge_a: assert property ($fell(ssN) |=> $stable(sclk) [*6])
      else $error("clock edge too soon after select");
   frame_limit_a: assert property (togCnt_r <= 5'h10)
      else $error("more than one byte in a frame");
   frame_count_a: assert property ($rose(ssN) |-> togCnt_r == 5'h10)
      else $error("frame not a whole byte");
   idle_level_a: assert property ($rose(ssN) |-> sclk == idleClk_r)
      else $error("clock idle level changed");
   lead_hold_a: assert property (!ssN && $changed(sclk) && !togCnt_r[0] |-> $stable(mosi))
      else $error("mosi moved at capture edge");
   slave_pads_a: assert property (!ssN |-> !sclkDOe && !mosiDOe)
      else $error("slave drives master pins");
   wire_join_a: assert property (mosiHOe && !mosiDOe |-> mosi == mosiH)
      else $error("mosi wire differs from master");

   cover property ($fell(ssN));
   cover property ($rose(ssN) && togCnt_r == 5'h10);
   cover property (misoDOe && !ssN);
endmodule

/* verification/tb_spi_slave_select_transfer_control.sv */
`timescale 1ns/100ps
`include "ssp_consts.svh"
module tb_spi_slave_select_transfer_control;
   logic        clk, rst_n, irq;
   logic [3:0]  awaddr, araddr, wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic        start, clock_polarity_select, drive, busy, done, rie, pol, od;
   logic [7:0]  txByte, rxByte, dv, hv;
   int          n_mismatch, total_checks, k;

   ssp_link_if i_ssp_link_if ();
   ssp_port i_ssp_port (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .irq(irq), .link(i_ssp_link_if));
   ssp_master_end i_ssp_master_end (.clk(clk), .rst_n(rst_n), .start(start),
      .txByte(txByte), .clock_polarity_select(clock_polarity_select), .drive(drive), .busy(busy), .done(done),
      .rxByte(rxByte), .link(i_ssp_link_if));
   ssp_link_monitor i_ssp_link_monitor (.clk(clk), .rst_n(rst_n),
      .sclk(i_ssp_link_if.sclk), .mosi(i_ssp_link_if.mosi), .ssN(i_ssp_link_if.ssN),
      .mosiH(i_ssp_link_if.mosiH), .mosiHOe(i_ssp_link_if.mosiHOe),
      .mosiDOe(i_ssp_link_if.mosiDOe), .sclkDOe(i_ssp_link_if.sclkDOe),
      .misoDOe(i_ssp_link_if.misoDOe));

   always #25 clk = ~clk;

   // ==========================================
   // checking and closing
   task end_sim;
      $display("mismatches %0d of %0d checks", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   task tmo;
      chk(32'h0, 32'h1);
      end_sim();
   endtask
   function automatic logic [7:0] ctrl_of(input logic ie, input logic p, input logic o);
      return {ie, 2'h0, p, 1'h0, o, 2'h2};
   endfunction

   // ==========================================
   // bus and link tasks
   task axi_wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] rs);
      int i;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      if (i == 64) tmo();
      rs = bresp;
      bready <= 1'h0;
   endtask
   task axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      int i;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      if (i == 64) tmo();
      v = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   task xfer(input logic [7:0] t);
      int i;
      @(posedge clk);
      txByte <= t;
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      for (i = 0; i < 400; i++) begin
         @(posedge clk);
         if (done === 1'h1) break;
      end
      if (i == 400) tmo();
   endtask

   // ==========================================
   // main sequence
   initial begin
      clk = 0; rst_n = 0; awaddr = 0; araddr = 0; wstrb = 4'hf; wdata = 0;
      awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      start = 0; txByte = 0; clock_polarity_select = 0; drive = 1;
      n_mismatch = 0; total_checks = 0;
      void'($urandom(46296));
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      axi_rd(`SSP_ADDR_CTRL, d, r);
      chk(d, 32'h20);
      chk(32'(irq), 32'h0);
      axi_wr(4'h1, 8'hff, r);
      chk(32'(r), 32'(`SSP_RESP_SLVERR));
      axi_wr(`SSP_ADDR_MASK, 8'h01, r);
      for (k = 0; k < 6; k++) begin
         rie = (k != 2);
         pol = (k == 4);
         od = (k == 3);
         dv = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($urandom);
         hv = 8'($urandom);
         axi_wr(`SSP_ADDR_CTRL, ctrl_of(rie, pol, od), r);
         clock_polarity_select <= pol;
         axi_rd(`SSP_ADDR_CTRL, d, r);
         chk(d, 32'(ctrl_of(rie, pol, od)));
         axi_wr(`SSP_ADDR_DATA, dv, r);
         chk(32'(r), 32'(`SSP_RESP_OKAY));
         repeat (12) @(posedge clk);
         chk(32'(i_ssp_link_if.sclk), 32'(pol));
         chk(32'(i_ssp_link_if.miso), 32'h1);
         xfer(hv);
         chk(32'(rxByte), 32'(dv));
         repeat (8) @(posedge clk);
         chk(32'(irq), 32'(rie));
         axi_rd(`SSP_ADDR_DATA, d, r);
         chk(d, 32'(hv));
         axi_rd(`SSP_ADDR_STAT, d, r);
         chk(d, 32'h5);
         chk(32'(irq), 32'h0);
      end
      axi_wr(`SSP_ADDR_DATA, 8'h3c, r);
      repeat (12) @(posedge clk);
      fork
         xfer(8'h5a);
         begin
            repeat (20) @(posedge clk);
            axi_wr(`SSP_ADDR_DATA, 8'hc3, r);
         end
      join
      chk(32'(rxByte), 32'h3c);
      repeat (12) @(posedge clk);
      xfer(8'ha5);
      chk(32'(rxByte), 32'hc3);
      // device as master, far end silent: miso floats to its pull-up
      drive <= 1'h0;
      axi_wr(`SSP_ADDR_CTRL, 8'h22, r);
      axi_wr(`SSP_ADDR_DATA, 8'h96, r);
      repeat (100) @(posedge clk);
      chk(32'(i_ssp_link_if.sclk), 32'h0);
      axi_rd(`SSP_ADDR_DATA, d, r);
      chk(d, 32'hff);
      end_sim();
   end
endmodule
